/* src/speech_rom_card_pkg.sv */
// Package with constants and carrier types for the speech ROM card decoder
package speech_rom_card_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int BUS_WIDTH      = 8;
  localparam int ADDR_WIDTH     = 20;
  localparam int SLOT_SW_WIDTH  = 3;
  localparam int ROW_WIDTH      = 4;
  localparam int COL_WIDTH      = 2;

  // ************************************************************
  // Address field layout (high, medium, low parts)
  // ************************************************************
  localparam int HIGH_LSB       = 16;
  localparam int HIGH_WIDTH     = 4;
  localparam int MED_LSB        = 8;
  localparam int LOW_LSB        = 0;

  // Card range: 256 kbytes, card number sits above the 18 offset bits
  localparam int OFFSET_WIDTH   = 18;
  localparam int VCARD_BIT      = 17;
  localparam int CARD_NUM_LSB   = 18;
  localparam int CARD_NUM_WIDTH = 2;

  // Each memory device covers 16 kbytes; 4 rows by 2 columns decode 8 devices
  localparam int DEV_ADDR_WIDTH = 14;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [BUS_WIDTH-1:0] HIGH_RESET = 8'h00;
  localparam logic [BUS_WIDTH-1:0] MED_RESET  = 8'h00;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic                 load_high;
    logic                 load_medium;
    logic                 data_select;
    logic                 write_strobe;
    logic [BUS_WIDTH-1:0] data;
  } backplane_type;

  typedef struct packed {
    logic [ROW_WIDTH-1:0]      row_select_n;
    logic [COL_WIDTH-1:0]      col_output_n;
    logic [ROW_WIDTH-1:0]      write_enable_n;
    logic [DEV_ADDR_WIDTH-1:0] device_addr;
  } memory_ctrl_type;

endpackage : speech_rom_card_pkg

/* src/speech_rom_card_address_decode.sv */
// Backplane address assembly and decode for a speech ROM card
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1: Builds 20-bit address from 8-bit transfers
// R2: Controller loads high part first
// R3: Controller then loads medium part
// R4: Low part used straight from bus
// R5: Decode gives range, chip and write enables
// R6: Card enable in range; drives buffer, rows
// R7: Row and column decodes flag valid addresses
// R8: Columns enable outputs; rows select chips
// R9: Data gated by strobe and card enable
// R10: 256 kbytes as virtual cards 0, 1
// R11: Card number taken from three-position switch
// R12: Data valid after high, medium loaded
module speech_rom_card_address_decode
  import speech_rom_card_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_reset_n,
  // Backplane from the controller
  input  wire backplane_type             i_backplane,
  // Configuration switch
  input  wire logic [SLOT_SW_WIDTH-1:0]  i_card_switch,
  // Read data from the memory devices
  input  wire logic [BUS_WIDTH-1:0]      i_memory_data,
  // Memory device control
  output memory_ctrl_type                o_memory_ctrl,
  // Data buffer toward the backplane, card enable, data valid and assembled address
  output logic [BUS_WIDTH-1:0]           o_data,
  output logic                           o_data_oe,
  output logic                           o_card_enable,
  output logic                           o_data_valid,
  output logic [ADDR_WIDTH-1:0]          o_address
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Backplane pins come from the controller's timing, so every one is
  // passed through two stages before any decode looks at it.
  backplane_type              bp_meta_reg,  bp_meta_next;
  backplane_type              bp_sync_reg,  bp_sync_next;
  logic [SLOT_SW_WIDTH-1:0]   sw_meta_reg,  sw_meta_next;
  logic [SLOT_SW_WIDTH-1:0]   sw_sync_reg,  sw_sync_next;
  logic [BUS_WIDTH-1:0]       mem_meta_reg, mem_meta_next;
  logic [BUS_WIDTH-1:0]       mem_sync_reg, mem_sync_next;

  always_comb begin
    bp_meta_next  = i_backplane;
    bp_sync_next  = bp_meta_reg;
    sw_meta_next  = i_card_switch;
    sw_sync_next  = sw_meta_reg;
    mem_meta_next = i_memory_data;
    mem_sync_next = mem_meta_reg;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bp_meta_reg  <= '0;
      bp_sync_reg  <= '0;
      sw_meta_reg  <= '0;
      sw_sync_reg  <= '0;
      mem_meta_reg <= '0;
      mem_sync_reg <= '0;
    end else begin
      bp_meta_reg  <= bp_meta_next;
      bp_sync_reg  <= bp_sync_next;
      sw_meta_reg  <= sw_meta_next;
      sw_sync_reg  <= sw_sync_next;
      mem_meta_reg <= mem_meta_next;
      mem_sync_reg <= mem_sync_next;
    end
  end

  // ************************************************************
  // Decode functions
  // ************************************************************
  function automatic logic [ROW_WIDTH-1:0] one_hot_low(input logic [1:0] sel,
                                                       input logic       en);
    logic [ROW_WIDTH-1:0] v;
    v = '1;
    if (en) begin
      v[sel] = 1'b0;
    end
    return v;
  endfunction : one_hot_low

  // ************************************************************
  // Address holding registers
  // ************************************************************
  typedef enum logic [1:0] {
    WAIT_HIGH,
    WAIT_MEDIUM,
    ADDR_READY
  } load_state_type;

  logic [BUS_WIDTH-1:0]  high_reg,  high_next;
  logic [BUS_WIDTH-1:0]  med_reg,   med_next;
  load_state_type        state_reg, state_next;

  always_comb begin
    high_next  = high_reg;
    med_next   = med_reg;
    state_next = state_reg;
    // A new high load always restarts the sequence
    if (bp_sync_reg.load_high) begin
      high_next  = bp_sync_reg.data; // see R2
      state_next = WAIT_MEDIUM;
    end else if (bp_sync_reg.load_medium) begin
      med_next = bp_sync_reg.data; // see R3
      case (state_reg)
        WAIT_MEDIUM: state_next = ADDR_READY;
        ADDR_READY:  state_next = ADDR_READY;
        WAIT_HIGH:   state_next = WAIT_HIGH;
        default:     state_next = WAIT_HIGH;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      high_reg  <= HIGH_RESET;
      med_reg   <= MED_RESET;
      state_reg <= WAIT_HIGH;
    end else begin
      high_reg  <= high_next;
      med_reg   <= med_next;
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Address decode and outputs
  // ************************************************************
  logic [ADDR_WIDTH-1:0]  full_addr;
  logic                   in_range;
  logic                   sel_active;
  memory_ctrl_type        mem_ctrl_next;
  logic [BUS_WIDTH-1:0]   data_next;
  logic                   data_oe_next;
  logic                   card_enable_next;
  logic                   data_valid_next;

  memory_ctrl_type        mem_ctrl_reg;
  logic [BUS_WIDTH-1:0]   data_reg;
  logic                   data_oe_reg;
  logic                   card_enable_reg;
  logic                   data_valid_reg;
  logic [ADDR_WIDTH-1:0]  address_reg;

  always_comb begin
    // Low part is never latched; it comes live from the bus
    full_addr = {high_reg[HIGH_WIDTH-1:0], med_reg, bp_sync_reg.data}; // see R1, R4
    // Switch low bits give the 256-kbyte window; top switch bit is spare
    in_range  = (full_addr[ADDR_WIDTH-1:CARD_NUM_LSB] ==
                 sw_sync_reg[CARD_NUM_WIDTH-1:0]); // see R6, R10, R11
    sel_active = bp_sync_reg.data_select && (state_reg == ADDR_READY);
    card_enable_next = in_range && sel_active; // see R5, R6
    // Rows act as chip selects; bit 17 picks virtual card 0 or 1
    mem_ctrl_next.row_select_n = one_hot_low(
      {full_addr[VCARD_BIT], full_addr[DEV_ADDR_WIDTH]}, card_enable_next); // see R7, R8, R10
    // Columns open the device outputs only for reads
    mem_ctrl_next.col_output_n = card_enable_next && !bp_sync_reg.write_strobe
                                 ? {~full_addr[DEV_ADDR_WIDTH+1], full_addr[DEV_ADDR_WIDTH+1]}
                                 : '1; // see R7, R8
    mem_ctrl_next.write_enable_n = bp_sync_reg.write_strobe
                                   ? mem_ctrl_next.row_select_n : '1; // see R5
    mem_ctrl_next.device_addr = full_addr[DEV_ADDR_WIDTH-1:0];
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_ctrl_reg    <= '{row_select_n: '1, col_output_n: '1,
                           write_enable_n: '1, device_addr: '0};
      card_enable_reg <= 1'b0;
      address_reg     <= '0;
    end else begin
      mem_ctrl_reg    <= mem_ctrl_next;
      card_enable_reg <= card_enable_next;
      address_reg     <= full_addr;
    end
  end

  // ************************************************************
  // Data buffer toward the backplane
  // ************************************************************
  // Memory data lags its pins by the two sync stages, so the controller
  // must hold the low byte for the whole data select phase.
  always_comb begin
    // Buffer drives only while card enable is up and write strobe is down
    data_oe_next    = card_enable_next && !bp_sync_reg.write_strobe; // see R9
    data_next       = '0;
    if (data_oe_next) begin
      data_next = mem_sync_reg; // see R9
    end
    data_valid_next = data_oe_next; // see R12
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_reg       <= '0;
      data_oe_reg    <= 1'b0;
      data_valid_reg <= 1'b0;
    end else begin
      data_reg       <= data_next;
      data_oe_reg    <= data_oe_next;
      data_valid_reg <= data_valid_next;
    end
  end

  assign o_memory_ctrl = mem_ctrl_reg;
  assign o_data        = data_reg;
  assign o_data_oe     = data_oe_reg;
  assign o_card_enable = card_enable_reg;
  assign o_data_valid  = data_valid_reg;
  assign o_address     = address_reg;

endmodule : speech_rom_card_address_decode

`default_nettype wire

/* dv/speech_rom_card_props.sv */
// Checker of the speech ROM card decode ports
`timescale 1ns/100ps
`default_nettype none
module speech_rom_card_props
  import speech_rom_card_pkg::*;
(
  input wire logic                     i_clock,
  input wire logic                     i_reset_n,
  input wire backplane_type            i_backplane,
  input wire logic [SLOT_SW_WIDTH-1:0] i_card_switch,
  input wire memory_ctrl_type          o_memory_ctrl,
  input wire logic [BUS_WIDTH-1:0]     o_data,
  input wire logic                     o_data_oe,
  input wire logic                     o_card_enable,
  input wire logic                     o_data_valid,
  input wire logic [ADDR_WIDTH-1:0]    o_address
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  oe_card_a: assert property (o_data_oe |-> o_card_enable)
    else $error("buffer on without card enable");
  valid_oe_a: assert property (o_data_valid == o_data_oe)
    else $error("valid differs from buffer enable");
  idle_data_a: assert property (!o_data_oe |-> o_data == 8'h00)
    else $error("data not quiet");
  card_range_a: assert property (o_card_enable |->
    o_address[19:18] == $past(i_card_switch[1:0], 3)) else $error("card enable out of range");
  low_live_a: assert property ($past(i_reset_n, 3) |->
    o_address[7:0] == $past(i_backplane.data, 3)) else $error("low part not live");
  strobe_gate_a: assert property ($past(i_reset_n, 3) &&
    !$past(i_backplane.data_select, 3) |-> !o_data_oe) else $error("data without strobe");
  rows_off_a: assert property (!o_card_enable |-> &o_memory_ctrl.row_select_n)
    else $error("row select without card enable");
  row_index_a: assert property (o_card_enable |-> o_memory_ctrl.row_select_n ==
    ~(4'h1 << {o_address[17], o_address[14]})) else $error("wrong row select");
  col_index_a: assert property (o_data_oe |->
    o_memory_ctrl.col_output_n == ~(2'h1 << o_address[15])) else $error("wrong column");
  write_gate_a: assert property (!o_card_enable |-> &o_memory_ctrl.write_enable_n)
    else $error("write enable without card enable");
  cover property (o_data_oe);
  cover property (!(&o_memory_ctrl.write_enable_n));
  cover property ($fell(o_data_oe));
endmodule : speech_rom_card_props
bind speech_rom_card_address_decode speech_rom_card_props i_props (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_backplane(i_backplane),
  .i_card_switch(i_card_switch), .o_memory_ctrl(o_memory_ctrl), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_card_enable(o_card_enable), .o_data_valid(o_data_valid),
  .o_address(o_address));
`default_nettype wire

/* dv/speech_ctrl_model.sv */
// Announcement controller model driving the backplane
`timescale 1ns/100ps
`default_nettype none
module speech_ctrl_model
  import speech_rom_card_pkg::*;
(
  input  wire logic    i_clock,
  output var backplane_type o_backplane
);
  initial o_backplane = '0;
  task automatic step(input logic [3:0] c, input logic [7:0] d);
    @(posedge i_clock);
    o_backplane <= {c, d};
  endtask : step
  // Skipping the high load is how a scenario breaks the order on purpose
  task automatic send(input logic hi, input logic [7:0] h, m, l, input logic ws);
    if (hi) step(4'h8, h);
    step(4'h4, m);
    step(ws ? 4'h3 : 4'h2, l);
  endtask : send
  // Released bus shows the inverse, not a stale copy
  task automatic idle();
    step(4'h0, ~o_backplane.data);
  endtask : idle
endmodule : speech_ctrl_model
`default_nettype wire

/* dv/tb_speech_rom_card_address_decode.sv */
// Testbench of the speech ROM card decode
`timescale 1ns/100ps
`default_nettype none
module tb_speech_rom_card_address_decode;
  import speech_rom_card_pkg::*;
  logic i_clock, i_reset_n, oe, ce, dv;
  logic [2:0] sw;
  logic [7:0] mem, od;
  logic [19:0] addr;
  backplane_type bp;
  memory_ctrl_type mc;
  int err_count, n_compared;
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  speech_rom_card_address_decode i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_backplane(bp), .i_card_switch(sw), .i_memory_data(mem), .o_memory_ctrl(mc),
    .o_data(od), .o_data_oe(oe), .o_card_enable(ce), .o_data_valid(dv), .o_address(addr));
  speech_ctrl_model i_ctrl (.i_clock(i_clock), .o_backplane(bp));
  task automatic check(input logic c, input string msg);
    n_compared++;
    if (c !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic access(input logic hi, input logic [7:0] h, m, l, input logic ws,
                        input logic [2:0] s);
    logic [19:0] a;
    logic hit, rd;
    a = {h[3:0], m, l};
    hit = hi && (a[19:18] == s[1:0]);
    rd = hit && !ws;
    @(posedge i_clock);
    sw <= s;
    mem <= 8'h5A ^ l;
    i_ctrl.send(hi, h, m, l, ws);
    repeat (8) @(posedge i_clock);
    #1;
    check(addr === a, "address");
    check(ce === hit, "card enable");
    check(oe === rd && dv === rd, "buffer enable");
    check(od === (rd ? (8'h5A ^ l) : 8'h00), "data");
    if (hit) begin
      check(mc.row_select_n === ~(4'h1 << {a[17], a[14]}), "row");
      check(mc.write_enable_n === (ws ? ~(4'h1 << {a[17], a[14]}) : 4'hF), "write");
      check(mc.device_addr === a[13:0], "device address");
    end else begin
      check(&mc.row_select_n && &mc.write_enable_n, "no select");
    end
    if (rd) check(mc.col_output_n === ~(2'h1 << a[15]), "column");
    i_ctrl.idle();
    repeat (4) @(posedge i_clock);
    #1;
    check(oe === 1'b0 && od === 8'h00, "strobe drop");
  endtask : access
  task automatic scen_medium_first();
    access(1'b0, 8'h00, 8'h12, 8'h34, 1'b0, 3'h0);
  endtask : scen_medium_first
  task automatic scen_card_sweep();
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        access(1'b1, {4'hF, s[1:0], v[0], 1'b1}, {v[0], ~v[0], 6'h15},
               8'h80 | s[7:0], 1'b0, {v[0], s[1:0]});
      end
    end
  endtask : scen_card_sweep
  task automatic scen_out_of_range();
    access(1'b1, 8'h0B, 8'hC3, 8'h7E, 1'b0, 3'h1);
  endtask : scen_out_of_range
  task automatic scen_write();
    access(1'b1, 8'h06, 8'h40, 8'h01, 1'b1, 3'h1);
  endtask : scen_write
  task automatic scen_low_reload();
    access(1'b1, 8'h05, 8'hA6, 8'h10, 1'b0, 3'h1);
    i_ctrl.step(4'h2, 8'hEF);
    mem <= 8'h5A ^ 8'hEF;
    repeat (8) @(posedge i_clock);
    #1;
    check(addr === 20'h5A6EF && ce === 1'b1, "low reload address");
    check(oe === 1'b1 && od === (8'h5A ^ 8'hEF), "low reload data");
    i_ctrl.idle();
    repeat (4) @(posedge i_clock);
    #1;
    check(oe === 1'b0, "low reload end");
  endtask : scen_low_reload
  task automatic scen_reset_midrun();
    access(1'b1, 8'h02, 8'h5C, 8'h21, 1'b0, 3'h0);
    i_ctrl.step(4'h2, 8'h21);
    repeat (4) @(posedge i_clock);
    #1;
    check(oe === 1'b1 && od === (8'h5A ^ 8'h21), "read before reset");
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    #1;
    check(oe === 1'b0 && ce === 1'b0 && dv === 1'b0 && od === 8'h00, "reset buffer");
    check(addr === 20'h0 && &mc.row_select_n && &mc.write_enable_n, "reset selects");
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    #1;
    check(ce === 1'b0 && oe === 1'b0 && addr === 20'h0, "first edge after release");
    repeat (4) @(posedge i_clock);
    #1;
    check(ce === 1'b0 && oe === 1'b0 && addr === 20'h00021, "load lost in reset");
    i_ctrl.idle();
    access(1'b0, 8'h00, 8'h34, 8'h56, 1'b0, 3'h0);
  endtask : scen_reset_midrun
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
  initial begin
    i_reset_n = 1'b0;
    sw = 3'h0;
    mem = 8'h00;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    scen_medium_first();
    scen_card_sweep();
    scen_out_of_range();
    scen_write();
    scen_low_reload();
    scen_reset_midrun();
    report_and_stop();
  end
endmodule : tb_speech_rom_card_address_decode
`default_nettype wire
